/* File: i2c_bus_enable.sv */
// enable, busy tracking, start/stop requests and reserved-transmission wait
`timescale 1ns/1ns
module i2c_bus_enable (
    // system clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link sampling clock
    input wire logic linkClk,
    // configuration
    input wire logic unitEnable,
    input wire logic stopInitSelect,
    input wire logic stopIrqEnable,
    // request writes, one-cycle strobes
    input wire i2c_en_pkg::busReq_t reqWrite,
    input wire logic dataWrite,
    input wire logic [7:0] dataIn,
    // status
    output logic busBusy,
    output logic masterStatus,
    output i2c_en_pkg::busReq_t reqPending,
    output logic stopIrq,
    output logic xferStart,
    output logic [7:0] shiftData,
    // open-drain lines
    input wire i2c_en_pkg::linePins_t lineIn,
    output i2c_en_pkg::linePins_t lineOut,
    output i2c_en_pkg::linePins_t lineOe
);
    import i2c_en_pkg::*;

    // ************************************************************
    // link domain: line sampling and condition detection
    // ************************************************************
    typedef struct packed {
        linePins_t meta;
        linePins_t sync;
        linePins_t prev;
        logic startTgl;
        logic stopTgl;
    } linkRegs_t;

    linkRegs_t lk;
    linkRegs_t next_lk;
    logic lkStart;
    logic lkStop;

    always_comb begin
        next_lk = lk;
        next_lk.meta = lineIn;
        next_lk.sync = lk.meta;
        next_lk.prev = lk.sync;
        // sda falling while scl high is a start, rising is a stop
        lkStart = lk.sync.scl && lk.prev.scl && lk.prev.sda && !lk.sync.sda;
        lkStop = lk.sync.scl && lk.prev.scl && !lk.prev.sda && lk.sync.sda;
        if (lkStart) begin
            next_lk.startTgl = !lk.startTgl;
        end
        if (lkStop) begin
            next_lk.stopTgl = !lk.stopTgl;
        end
    end

    always_ff @(posedge linkClk or negedge rst_n) begin
        if (!rst_n) begin
            lk <= '{meta: LINES_IDLE, sync: LINES_IDLE, prev: LINES_IDLE,
                    startTgl: 1'h0, stopTgl: 1'h0};
        end else begin
            lk <= next_lk;
        end
    end

    // ************************************************************
    // system domain state
    // ************************************************************
    typedef struct packed {
        logic [2:0] startMeta;
        logic [2:0] stopMeta;
        logic enPrev;
        logic busy;
        logic master;
        busReq_t req;
        logic irq;
        logic xfer;
        logic [7:0] data;
        ctlState_t state;
        logic [CNT_W-1:0] cnt;
        linePins_t oe;
    } ctlRegs_t;

    ctlRegs_t r;
    ctlRegs_t next_r;
    logic startSeen;
    logic stopSeen;
    logic enRise;

    // toggle crossings: bit 0 is only read by bit 1
    assign startSeen = r.startMeta[2] ^ r.startMeta[1];
    assign stopSeen = r.stopMeta[2] ^ r.stopMeta[1];
    assign enRise = unitEnable && !r.enPrev;

    always_comb begin
        next_r = r;
        next_r.startMeta = {r.startMeta[1:0], lk.startTgl};
        next_r.stopMeta = {r.stopMeta[1:0], lk.stopTgl};
        next_r.enPrev = unitEnable;
        next_r.xfer = 1'h0;
        // wakeup filtering never masks the stop interrupt
        next_r.irq = unitEnable && stopSeen && stopIrqEnable;
        if (dataWrite) begin
            next_r.data = dataIn;
        end

        // busy flag
        if (!unitEnable) begin
            next_r.busy = BUSY_RST;
        end else if (enRise) begin
            // real bus state is unknown at enable, so the option decides
            next_r.busy = !stopInitSelect;
        end else if (startSeen) begin
            next_r.busy = 1'h1;
        end else if (stopSeen) begin
            next_r.busy = 1'h0;
        end

        if (r.cnt != CNT_ZERO) begin
            next_r.cnt = r.cnt - 1'h1;
        end

        case (r.state)
            ST_IDLE: begin
                next_r.oe = 2'h0;
                if (r.req.stopReq) begin
                    next_r.state = ST_STOP_LOW;
                    next_r.oe.sda = 1'h1;
                    next_r.cnt = STOP_SETUP_CNT;
                end else if (r.req.startReq && r.busy) begin
                    next_r.state = ST_RESERVED;
                end else if (r.req.startReq) begin
                    next_r.state = ST_GEN_START;
                    next_r.oe.sda = 1'h1;
                    next_r.cnt = START_HOLD_CNT;
                end
            end
            ST_GEN_START: begin
                if (r.cnt == CNT_ZERO) begin
                    next_r.oe.scl = 1'h1;
                    next_r.req.startReq = 1'h0;
                    next_r.master = 1'h1;
                    next_r.xfer = 1'h1;
                    next_r.state = ST_OWN;
                end
            end
            ST_OWN: begin
                if (r.req.stopReq) begin
                    next_r.oe = 2'h3;
                    next_r.cnt = STOP_SETUP_CNT;
                    next_r.state = ST_STOP_LOW;
                end
            end
            ST_STOP_LOW: begin
                if (r.cnt == CNT_ZERO) begin
                    next_r.oe.scl = 1'h0;
                    next_r.cnt = STOP_SETUP_CNT;
                    next_r.state = ST_STOP_SETUP;
                end
            end
            ST_STOP_SETUP: begin
                if (r.cnt == CNT_ZERO) begin
                    next_r.oe.sda = 1'h0;
                    next_r.req.stopReq = 1'h0;
                    next_r.master = 1'h0;
                    next_r.state = ST_IDLE;
                end
            end
            ST_RESERVED: begin
                // without the interrupt nothing wakes software, so hold here
                if (stopSeen && stopIrqEnable) begin
                    next_r.state = ST_WAIT_DATA;
                end else begin
                    next_r.state = ST_RESERVED;
                end
            end
            ST_WAIT_DATA: begin
                if (dataWrite) begin
                    next_r.state = ST_GEN_START;
                    next_r.oe.sda = 1'h1;
                    next_r.cnt = START_HOLD_CNT;
                end
            end
            default: begin
                next_r.state = ST_IDLE;
            end
        endcase

        // a write landing on the clearing cycle still sets the bit
        if (reqWrite.startReq) begin
            next_r.req.startReq = 1'h1;
        end
        if (reqWrite.stopReq) begin
            next_r.req.stopReq = 1'h1;
        end

        if (!unitEnable) begin
            next_r.state = ST_IDLE;
            next_r.oe = 2'h0;
            next_r.master = 1'h0;
            next_r.req = 2'h0;
            next_r.cnt = CNT_ZERO;
            next_r.irq = 1'h0;
            next_r.xfer = 1'h0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{startMeta: 3'h0, stopMeta: 3'h0, enPrev: 1'h0, busy: BUSY_RST,
                   master: 1'h0, req: 2'h0, irq: 1'h0, xfer: 1'h0, data: DATA_RST,
                   state: ST_IDLE, cnt: CNT_ZERO, oe: 2'h0};
        end else begin
            r <= next_r;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign busBusy = r.busy;
    assign masterStatus = r.master;
    assign reqPending = r.req;
    assign stopIrq = r.irq;
    assign xferStart = r.xfer;
    assign shiftData = r.data;
    assign lineOe = r.oe;
    assign lineOut = 2'h0;

    // ************************************************************
    // checks
    // ************************************************************
    sequence enableOptClear;
        unitEnable && !r.enPrev && !stopInitSelect;
    endsequence
    sequence enableOptSet;
        unitEnable && !r.enPrev && stopInitSelect;
    endsequence
    sequence resvDataIn;
        r.state == ST_WAIT_DATA && dataWrite && unitEnable;
    endsequence

    chk_busy_after_enable: assert property (@(posedge clk) disable iff (!rst_n)
        enableOptClear |=> busBusy)
        else $error("busy not set after enable with option clear");
    chk_free_after_enable: assert property (@(posedge clk) disable iff (!rst_n)
        enableOptSet |=> !busBusy)
        else $error("busy not clear after enable with option set");
    chk_start_detect_toggle: assert property (@(posedge linkClk) disable iff (!rst_n)
        (lk.sync.scl && lk.prev.scl && lk.prev.sda && !lk.sync.sda)
        |=> lk.startTgl != $past(lk.startTgl))
        else $error("start pattern on lines not flagged");
    chk_start_sets_busy: assert property (@(posedge clk) disable iff (!rst_n)
        (unitEnable && r.enPrev && startSeen) |=> busBusy)
        else $error("busy not set by start");
    chk_stop_clears_busy: assert property (@(posedge clk) disable iff (!rst_n)
        (unitEnable && r.enPrev && stopSeen && !startSeen) |=> !busBusy)
        else $error("busy not cleared by stop");
    chk_stop_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
        (unitEnable && stopSeen) |=> stopIrq == $past(stopIrqEnable))
        else $error("stop interrupt does not follow its enable");
    chk_resv_release: assert property (@(posedge clk) disable iff (!rst_n)
        resvDataIn ##1 unitEnable [*1] |-> r.state == ST_GEN_START ##[1:1000] xferStart)
        else $error("reserved transfer not released by data write");
    chk_resv_stall: assert property (@(posedge clk) disable iff (!rst_n)
        (r.state == ST_RESERVED && unitEnable && !(stopSeen && stopIrqEnable))
        |=> r.state == ST_RESERVED && !xferStart)
        else $error("reserved transfer left wait without interrupt");
    chk_master_status: assert property (@(posedge clk) disable iff (!rst_n)
        xferStart |-> masterStatus && lineOe.scl && !reqPending.startReq)
        else $error("master status missing at transfer start");

endmodule : i2c_bus_enable

/* File: i2c_bus_peer.sv */
// behavioural peer master sharing the two-wire lines
`timescale 1ns/1ns
module i2c_bus_peer (
    // open-drain pulls, 1 = hold line low
    output logic sclLow,
    output logic sdaLow
);
    // released between frames so the pull-ups show idle high
    initial begin
        sclLow = 1'h0;
        sdaLow = 1'h0;
    end
    // 400 ns steps keep conditions well over three link periods apart
    task automatic startCond();
        sdaLow = 1'h1;
        #400;
        sclLow = 1'h1;
        #400;
    endtask : startCond
    task automatic stopCond();
        sdaLow = 1'h1;
        #400;
        sclLow = 1'h0;
        #400;
        sdaLow = 1'h0;
        #400;
    endtask : stopCond
endmodule : i2c_bus_peer

/* File: i2c_en_pkg.sv */
// shared constants, states and carriers for the two-wire bus enable block
package i2c_en_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned START_HOLD_NS = 4000;
    localparam int unsigned STOP_SETUP_NS = 4000;
    localparam int unsigned CNT_W = 10;
    localparam int unsigned START_HOLD_CYC = (START_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned STOP_SETUP_CYC = (STOP_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam logic [CNT_W-1:0] START_HOLD_CNT = CNT_W'(START_HOLD_CYC - 1);
    localparam logic [CNT_W-1:0] STOP_SETUP_CNT = CNT_W'(STOP_SETUP_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic BUSY_RST = 1'h0;
    localparam logic [7:0] DATA_RST = 8'h00;

    // ************************************************************
    // controller states
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_GEN_START = 3'b001,
        ST_OWN = 3'b010,
        ST_STOP_LOW = 3'b011,
        ST_STOP_SETUP = 3'b100,
        ST_RESERVED = 3'b101,
        ST_WAIT_DATA = 3'b110
    } ctlState_t;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic scl;
        logic sda;
    } linePins_t;

    // line samplers start as an idle bus so reset makes no false condition
    localparam linePins_t LINES_IDLE = 2'h3;

    typedef struct packed {
        logic stopReq;
        logic startReq;
    } busReq_t;

endpackage : i2c_en_pkg

/* File: tb_i2c_bus_enable_and_reservation.sv */
// testbench for bus enable, busy tracking and reserved transmission
`timescale 1ns/1ns
module tb_i2c_bus_enable_and_reservation;
    import i2c_en_pkg::*;
    // ********************
    // signals
    // ********************
    logic clk = 1'h0;
    logic linkClk = 1'h0;
    logic rst_n = 1'h0;
    logic unitEnable = 1'h0;
    logic stopInitSelect = 1'h0;
    logic stopIrqEnable = 1'h0;
    logic dataWrite = 1'h0;
    logic [7:0] dataIn = 8'h00;
    busReq_t reqWrite = 2'h0;
    busReq_t reqPending;
    logic busBusy, masterStatus, stopIrq, xferStart;
    logic [7:0] shiftData;
    linePins_t lineIn, lineOut, lineOe;
    logic sclLow, sdaLow;
    int error_cnt = 0;
    int n_tests = 0;
    int xferCnt = 0;
    int irqCnt = 0;
    int x0, i0;
    // row: bit1 option, bit0 busy expected after enable
    logic [1:0] rows [2] = '{2'h1, 2'h2};

    // wired-and of all pulls, lines pulled up
    assign lineIn = {~lineOe.scl & ~sclLow, ~lineOe.sda & ~sdaLow};

    i2c_bus_enable dut (
        .clk(clk), .rst_n(rst_n), .linkClk(linkClk),
        .unitEnable(unitEnable), .stopInitSelect(stopInitSelect),
        .stopIrqEnable(stopIrqEnable), .reqWrite(reqWrite),
        .dataWrite(dataWrite), .dataIn(dataIn), .busBusy(busBusy),
        .masterStatus(masterStatus), .reqPending(reqPending),
        .stopIrq(stopIrq), .xferStart(xferStart), .shiftData(shiftData),
        .lineIn(lineIn), .lineOut(lineOut), .lineOe(lineOe)
    );
    i2c_bus_peer peer (.sclLow(sclLow), .sdaLow(sdaLow));

    always #5 clk = ~clk;
    initial begin
        #17;
        forever #40 linkClk = ~linkClk;
    end
    // mid-cycle sampling keeps the pulse counters clear of the launching edge
    always @(negedge clk) begin
        if (xferStart === 1'h1) xferCnt++;
        if (stopIrq === 1'h1) irqCnt++;
    end

    // ********************
    // tasks
    // ********************
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic req(input busReq_t r);
        reqWrite = r;
        tick(1);
        reqWrite = 2'h0;
    endtask : req
    // option changes only while disabled; lines idle when enabling
    task automatic enable(input logic opt);
        unitEnable = 1'h0;
        tick(2);
        stopInitSelect = opt;
        unitEnable = 1'h1;
        tick(3);
    endtask : enable
    task automatic end_sim();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        #200000;
        error_cnt++;
        end_sim();
    end

    initial begin
        tick(12);
        chk({busBusy, masterStatus, reqPending, stopIrq, xferStart, lineOe}, 8'h00);
        rst_n = 1'h1;
        tick(2);
        for (int i = 0; i < 2; i++) begin
            enable(rows[i][1]);
            chk(busBusy, rows[i][0]);
        end
        // initial stop before mastering, option clear
        stopIrqEnable = 1'h1;
        enable(1'h0);
        i0 = irqCnt;
        req(2'h2);
        tick(850);
        chk({busBusy, reqPending}, 8'h00);
        chk(8'(irqCnt - i0), 8'h01);
        // own start with stop interrupt off
        stopIrqEnable = 1'h0;
        x0 = xferCnt;
        chk(busBusy, 8'h00);
        req(2'h1);
        tick(1);
        chk(reqPending, 8'h01);
        tick(405);
        chk({masterStatus, lineOe.scl, reqPending}, 8'h0C);
        chk(8'(xferCnt - x0), 8'h01);
        chk(lineOut, 8'h00);
        i0 = irqCnt;
        req(2'h2);
        tick(850);
        chk({masterStatus, busBusy, reqPending, lineOe}, 8'h00);
        chk(8'(irqCnt - i0), 8'h00);
        // reservation with and without stop interrupt
        for (int ie = 0; ie < 2; ie++) begin
            enable(1'h1);
            peer.startCond();
            tick(40);
            chk(busBusy, 8'h01);
            stopIrqEnable = ie[0];
            x0 = xferCnt;
            i0 = irqCnt;
            req(2'h1);
            tick(500);
            chk(8'(xferCnt - x0), 8'h00);
            peer.stopCond();
            tick(40);
            chk(busBusy, 8'h00);
            dataIn = 8'hA5;
            dataWrite = 1'h1;
            tick(1);
            dataWrite = 1'h0;
            tick(410);
            chk(8'(xferCnt - x0), 8'(ie));
            chk(8'(irqCnt - i0), 8'(ie));
            chk(shiftData, 8'hA5);
        end
        end_sim();
    end
endmodule : tb_i2c_bus_enable_and_reservation
